// >>> rtl/link_pkg.sv
// shared constants and helpers for the 21-bit serial link pair
package link_pkg;
	localparam int WORD_BITS = 21;
	localparam int LANES = 3;
	localparam int SLOTS = 7;
	localparam int SLOT_W = 3;
	localparam logic [SLOT_W-1:0] SLOT_FIRST = 3'h0;
	localparam logic [SLOT_W-1:0] SLOT_LAST = 3'h6;
	localparam logic [SLOT_W-1:0] FCLK_HIGH_SLOTS = 3'h4;
	localparam logic [1:0] RX_SETUP_CYCLES = 2'h2;
	localparam int BUF_DEPTH = 2;
	localparam logic [WORD_BITS-1:0] WORD_RESET = 21'h000000;

	typedef logic [SLOT_W-1:0] slot_t;

	// word bit carried by a given lane in a given slot; slot 0 goes first
	function automatic int bit_index(input int lane, input slot_t slot);
		bit_index = lane * SLOTS + int'(slot);
	endfunction
endpackage

// >>> rtl/stream_if.sv
// valid/ready word stream between the link modules
`timescale 1ns/1ps
interface stream_if import link_pkg::*; #(parameter int WIDTH = WORD_BITS) ();
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;

	modport producer (output valid, output data, input ready);
	modport consumer (input valid, input data, output ready);
endinterface

// >>> rtl/word_buffer.sv
// small valid/ready fifo that holds captured words ahead of the serializer
`timescale 1ns/1ps
module word_buffer import link_pkg::*; #(
	parameter int WIDTH = WORD_BITS,
	parameter int DEPTH = BUF_DEPTH
) (
	input logic clk,
	input logic reset_n,
	stream_if.consumer fill,
	stream_if.producer drain
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] store_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [CW-1:0] count_q;
	logic push;
	logic pop;

	function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
		step = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign push = fill.valid && fill.ready;
	assign pop = drain.valid && drain.ready;
	assign fill.ready = (count_q != CW'(DEPTH));
	assign drain.valid = (count_q != '0);
	assign drain.data = store_q[rd_q];

	always_ff @(posedge clk) begin
		if (push) begin
			store_q[wr_q] <= fill.data;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_q <= '0;
			rd_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_q <= step(wr_q);
			end
			if (pop) begin
				rd_q <= step(rd_q);
			end
			count_q <= count_q + CW'(push) - CW'(pop);
		end
	end

	a_fifo_bounded: assert property (@(posedge clk) disable iff (!reset_n)
		count_q <= CW'(DEPTH))
		else $error("buffer count above depth");

	a_fifo_full_stall: assert property (@(posedge clk) disable iff (!reset_n)
		(count_q == CW'(DEPTH) && !pop) |=> (count_q == CW'(DEPTH)) && !fill.ready)
		else $error("full buffer accepted a word");
endmodule

// >>> rtl/serial_link_pair.sv
// 21-bit parallel-to-serial link: transmitter and receiver ends
// Contract
// - capture whole word every source clock rise
// - drive three complementary serial data lanes
// - forward word clock on its own lane
// - transmitter asleep: serial and clock outputs undriven
// - receiver takes three lanes plus clock lane
// - receiver presents word on 21 outputs
// - output strobe rises once word is valid
// - receiver asleep: parallel outputs forced low
// - seven bit slots per lane per word
`timescale 1ns/1ps
module serial_link_pair import link_pkg::*; (
	input logic clk,
	input logic reset_n,
	input logic source_strobe_clock,
	input logic [WORD_BITS-1:0] parallel_word_in,
	input logic tx_sleep_n,
	output logic [LANES-1:0] serial_lane_out_p,
	output logic [LANES-1:0] serial_lane_out_n,
	output logic serial_lane_oe_n,
	output logic forwarded_clock_out_p,
	output logic forwarded_clock_out_n,
	output logic forwarded_clock_oe_n,
	output logic tx_ready,
	input logic rx_sleep_n,
	input logic [LANES-1:0] serial_lane_in_p,
	input logic [LANES-1:0] serial_lane_in_n,
	input logic forwarded_clock_in_p,
	input logic forwarded_clock_in_n,
	output logic [WORD_BITS-1:0] parallel_word_out,
	output logic recovered_strobe_clock
);
	typedef enum logic {TX_IDLE, TX_SEND} tx_state_e;
	typedef enum logic {RX_WAIT, RX_COLLECT} rx_state_e;

	// source clock domain: one word per rising edge, flagged by a toggle
	logic [WORD_BITS-1:0] cap_word_q;
	logic cap_toggle_q;

	always_ff @(posedge source_strobe_clock or negedge reset_n) begin
		if (!reset_n) begin
			cap_word_q <= WORD_RESET;
			cap_toggle_q <= 1'b0;
		end else begin
			cap_word_q <= parallel_word_in;
			cap_toggle_q <= ~cap_toggle_q;
		end
	end

	a_capture_each_edge: assert property (@(posedge source_strobe_clock) disable iff (!reset_n)
		1'b1 |=> (cap_toggle_q != $past(cap_toggle_q)))
		else $error("source edge did not raise a capture");

	// pin and cross-domain synchronisers
	logic [2:0] tog_s;
	logic [1:0] tx_sleep_s;
	logic [1:0] rx_sleep_s;
	logic [LANES-1:0] lp_s1, lp_s2, ln_s1, ln_s2;
	logic [1:0] fp_s;
	logic [1:0] fn_s;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tog_s <= 3'h0;
			tx_sleep_s <= 2'h0;
			rx_sleep_s <= 2'h0;
			lp_s1 <= '0;
			lp_s2 <= '0;
			ln_s1 <= '0;
			ln_s2 <= '0;
			fp_s <= 2'h0;
			fn_s <= 2'h0;
		end else begin
			tog_s <= {tog_s[1:0], cap_toggle_q};
			tx_sleep_s <= {tx_sleep_s[0], tx_sleep_n};
			rx_sleep_s <= {rx_sleep_s[0], rx_sleep_n};
			lp_s1 <= serial_lane_in_p;
			lp_s2 <= lp_s1;
			ln_s1 <= serial_lane_in_n;
			ln_s2 <= ln_s1;
			fp_s <= {fp_s[0], forwarded_clock_in_p};
			fn_s <= {fn_s[0], forwarded_clock_in_n};
		end
	end

	logic tx_awake;
	logic rx_awake;
	assign tx_awake = tx_sleep_s[1];
	assign rx_awake = rx_sleep_s[1];

	// captured words enter the buffer; the source word holds for a whole
	// source period, far longer than the toggle takes to cross
	stream_if #(.WIDTH(WORD_BITS)) fill_s ();
	stream_if #(.WIDTH(WORD_BITS)) drain_s ();

	assign fill_s.valid = tog_s[2] ^ tog_s[1];
	assign fill_s.data = cap_word_q;

	word_buffer #(.WIDTH(WORD_BITS), .DEPTH(BUF_DEPTH)) u_buffer (
		.clk(clk),
		.reset_n(reset_n),
		.fill(fill_s),
		.drain(drain_s)
	);

	// serializer: one clk per slot, forwarded clock divided from clk
	tx_state_e tx_state_q, tx_state_d;
	slot_t tx_slot_q, tx_slot_d;
	logic [WORD_BITS-1:0] tx_word_q;
	logic [WORD_BITS-1:0] tx_src;
	logic [LANES-1:0] tx_lane_d;
	logic tx_fclk_d;
	logic tx_load;

	// asleep, the serializer keeps draining so no stale word is sent on wake
	assign drain_s.ready = !tx_awake || tx_state_q == TX_IDLE || tx_slot_q == SLOT_LAST;
	assign tx_load = drain_s.valid && drain_s.ready && tx_awake;
	assign tx_src = tx_load ? drain_s.data : tx_word_q;

	always_comb begin
		tx_state_d = tx_state_q;
		tx_slot_d = tx_slot_q;
		tx_lane_d = '0;
		tx_fclk_d = 1'b0;
		// sleep only blocks new loads: a frame in progress runs out behind
		// the raised enables, so the forwarded clock never shows a cut pulse
		if (tx_load) begin
			tx_state_d = TX_SEND;
			tx_slot_d = SLOT_FIRST;
		end else if (tx_state_q == TX_SEND && tx_slot_q != SLOT_LAST) begin
			tx_slot_d = tx_slot_q + 3'h1;
		end else begin
			tx_state_d = TX_IDLE;
		end
		if (tx_state_d == TX_SEND) begin
			for (int l = 0; l < LANES; l++) begin
				tx_lane_d[l] = tx_src[bit_index(l, tx_slot_d)];
			end
			tx_fclk_d = (tx_slot_d < FCLK_HIGH_SLOTS);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_state_q <= TX_IDLE;
			tx_slot_q <= SLOT_FIRST;
			tx_word_q <= WORD_RESET;
		end else begin
			tx_state_q <= tx_state_d;
			tx_slot_q <= tx_slot_d;
			if (tx_load) begin
				tx_word_q <= drain_s.data;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			serial_lane_out_p <= '0;
			serial_lane_out_n <= '1;
			forwarded_clock_out_p <= 1'b0;
			forwarded_clock_out_n <= 1'b1;
			serial_lane_oe_n <= 1'b1;
			forwarded_clock_oe_n <= 1'b1;
			tx_ready <= 1'b0;
		end else begin
			serial_lane_out_p <= tx_lane_d;
			serial_lane_out_n <= ~tx_lane_d;
			forwarded_clock_out_p <= tx_fclk_d;
			forwarded_clock_out_n <= ~tx_fclk_d;
			serial_lane_oe_n <= !tx_awake;
			forwarded_clock_oe_n <= !tx_awake;
			tx_ready <= fill_s.ready;
		end
	end

	a_lane_complement: assert property (@(posedge clk) disable iff (!reset_n)
		serial_lane_out_n == ~serial_lane_out_p)
		else $error("data lane pair not complementary");

	a_fclk_complement: assert property (@(posedge clk) disable iff (!reset_n)
		forwarded_clock_out_n == !forwarded_clock_out_p)
		else $error("clock lane pair not complementary");

	a_fclk_shape: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(forwarded_clock_out_p) |-> forwarded_clock_out_p [*4]
			##1 !forwarded_clock_out_p [*3])
		else $error("forwarded clock period is not seven slots");

	a_tx_sleep_hiz: assert property (@(posedge clk) disable iff (!reset_n)
		(!tx_sleep_n) [*3] |=> serial_lane_oe_n && forwarded_clock_oe_n)
		else $error("transmitter drives outputs while asleep");

	// receiver: lanes sampled on clk, frame starts at forwarded clock rise
	logic [LANES-1:0] rx_lane;
	logic rx_fclk;
	logic rx_fclk_q;
	logic rx_rise;
	slot_t rx_cur;
	rx_state_e rx_state_q;
	slot_t rx_slot_q;
	logic [WORD_BITS-1:0] rx_acc_q;
	logic word_done_q;
	logic [1:0] settle_q;

	assign rx_lane = lp_s2 & ~ln_s2;
	assign rx_fclk = fp_s[1] & ~fn_s[1];
	assign rx_rise = rx_fclk && !rx_fclk_q;
	assign rx_cur = rx_rise ? SLOT_FIRST : rx_slot_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_fclk_q <= 1'b0;
			rx_state_q <= RX_WAIT;
			rx_slot_q <= SLOT_FIRST;
			rx_acc_q <= WORD_RESET;
			word_done_q <= 1'b0;
		end else begin
			rx_fclk_q <= rx_fclk;
			word_done_q <= 1'b0;
			if (!rx_awake) begin
				rx_state_q <= RX_WAIT;
			end else if (rx_rise || rx_state_q == RX_COLLECT) begin
				for (int l = 0; l < LANES; l++) begin
					rx_acc_q[bit_index(l, rx_cur)] <= rx_lane[l];
				end
				if (rx_cur == SLOT_LAST) begin
					rx_state_q <= RX_WAIT;
					word_done_q <= 1'b1;
				end else begin
					rx_state_q <= RX_COLLECT;
					rx_slot_q <= rx_cur + 3'h1;
				end
			end
		end
	end

	// the word changes while the strobe is low and the strobe rises only
	// after a setup delay, so the sink's rising-edge sample is clean
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			parallel_word_out <= WORD_RESET;
			recovered_strobe_clock <= 1'b0;
			settle_q <= 2'h0;
		end else if (!rx_awake) begin
			parallel_word_out <= WORD_RESET;
			recovered_strobe_clock <= 1'b0;
			settle_q <= 2'h0;
		end else if (word_done_q) begin
			parallel_word_out <= rx_acc_q;
			recovered_strobe_clock <= 1'b0;
			settle_q <= RX_SETUP_CYCLES;
		end else if (settle_q != 2'h0) begin
			settle_q <= settle_q - 2'h1;
			recovered_strobe_clock <= (settle_q == 2'h1);
		end
	end

	a_rx_frame_len: assert property (@(posedge clk) disable iff (!reset_n)
		(rx_rise && rx_awake && rx_sleep_n) |-> ##7 word_done_q)
		else $error("received frame did not end after seven slots");

	a_rx_strobe_rise: assert property (@(posedge clk) disable iff (!reset_n)
		(word_done_q && rx_awake) |=> !recovered_strobe_clock
			##1 !recovered_strobe_clock ##1 recovered_strobe_clock)
		else $error("output strobe did not rise after new word");

	a_rx_sleep_low: assert property (@(posedge clk) disable iff (!reset_n)
		(!rx_sleep_n) [*3] |=> (parallel_word_out == WORD_RESET) && !recovered_strobe_clock)
		else $error("receiver outputs not low while asleep");
endmodule

// >>> testbench/far_end_model.sv
// behavioural companion chip: feeds the receiver pins and decodes the transmitter pins
`timescale 1ns/1ps
module far_end_model import link_pkg::*; (
	input logic clk,
	input logic [LANES-1:0] tx_lane_p,
	input logic [LANES-1:0] tx_lane_n,
	input logic tx_oe_n,
	input logic tx_fclk_p,
	input logic tx_fclk_n,
	output logic [LANES-1:0] lane_p,
	output logic [LANES-1:0] lane_n,
	output logic fclk_p,
	output logic fclk_n
);
	logic [WORD_BITS-1:0] got[$];
	logic [WORD_BITS-1:0] acc = 21'h000000;
	logic prev_fp = 1'h0;
	int slot = 7;
	int pair_bad = 0;

	initial begin
		lane_p = 3'h0;
		lane_n = 3'h7;
		fclk_p = 1'h0;
		fclk_n = 1'h1;
	end

	// the clock stands still between frames and lanes show the inverse of their last bit,
	// so a receiver that keeps sampling after slot 6 sees garbage
	task automatic send_word(input logic [WORD_BITS-1:0] w);
		for (int s = 0; s < SLOTS; s++) begin
			@(negedge clk);
			fclk_p = (s < 4);
			fclk_n = !fclk_p;
			for (int l = 0; l < LANES; l++) begin
				lane_p[l] = w[l * SLOTS + s];
			end
			lane_n = ~lane_p;
		end
		@(negedge clk);
		fclk_p = 1'h0;
		fclk_n = 1'h1;
		lane_p = ~lane_p;
		lane_n = ~lane_n;
	endtask

	always @(posedge clk) begin
		if (tx_oe_n === 1'h0 && tx_fclk_p === 1'h1 && prev_fp === 1'h0 && slot == SLOTS) begin
			slot = 0;
		end
		if (slot < SLOTS) begin
			for (int l = 0; l < LANES; l++) begin
				acc[l * SLOTS + slot] = tx_lane_p[l];
			end
			if (tx_lane_n !== ~tx_lane_p || tx_fclk_n !== ~tx_fclk_p || tx_fclk_p !== (slot < 4)) begin
				pair_bad++;
			end
			slot++;
			if (slot == SLOTS) begin
				got.push_back(acc);
			end
		end
		prev_fp = tx_fclk_p;
	end
endmodule

// >>> testbench/test_serial_link_pair.sv
// self-checking bench for the serial link pair
`timescale 1ns/1ps
module test_serial_link_pair import link_pkg::*;;
	logic clk = 1'h0;
	logic reset_n = 1'h1;
	logic src = 1'h0;
	logic tx_sleep_n = 1'h1;
	logic rx_sleep_n = 1'h1;
	logic [WORD_BITS-1:0] pw = 21'h000000;
	logic [WORD_BITS-1:0] wout;
	logic [LANES-1:0] lp, ln, rp, rn;
	logic lo, fp, fn, fo, rdy, rfp, rfn, strobe;
	int n_mismatch = 0;
	int n_tests = 0;
	logic [WORD_BITS-1:0] tbl[3] = '{21'h1FFFFF, 21'h155555, 21'h0AAAAA};

	serial_link_pair DUT (.clk(clk), .reset_n(reset_n), .source_strobe_clock(src),
		.parallel_word_in(pw), .tx_sleep_n(tx_sleep_n), .serial_lane_out_p(lp),
		.serial_lane_out_n(ln), .serial_lane_oe_n(lo), .forwarded_clock_out_p(fp),
		.forwarded_clock_out_n(fn), .forwarded_clock_oe_n(fo), .tx_ready(rdy),
		.rx_sleep_n(rx_sleep_n), .serial_lane_in_p(rp), .serial_lane_in_n(rn),
		.forwarded_clock_in_p(rfp), .forwarded_clock_in_n(rfn),
		.parallel_word_out(wout), .recovered_strobe_clock(strobe));
	far_end_model u (.clk(clk), .tx_lane_p(lp), .tx_lane_n(ln), .tx_oe_n(lo), .tx_fclk_p(fp),
		.tx_fclk_n(fn), .lane_p(rp), .lane_n(rn), .fclk_p(rfp), .fclk_n(rfn));

	always #2.5 clk = ~clk;
	// source clock phase offset keeps it unrelated to clk
	initial begin
		#3.3;
		forever #40 src = ~src;
	end

	task check(input string what, input logic [WORD_BITS-1:0] seen, input logic [WORD_BITS-1:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task t_reset;
		check("oe_n in reset", 21'({lo, fo}), 21'h000003);
		check("word in reset", wout, 21'h000000);
		check("strobe in reset", 21'(strobe), 21'h000000);
	endtask

	task t_tx_words;
		for (int i = 0; i < 3; i++) begin
			@(negedge clk);
			pw = tbl[i];
			@(posedge src);
		end
		// a source that uses only bit 0 holds every other input low
		@(negedge clk);
		pw = 21'h000001;
		@(posedge src);
		repeat (60) @(posedge clk);
		while (u.got.size() > 0 && u.got[0] === 21'h000000) begin
			void'(u.got.pop_front());
		end
		for (int i = 0; i < 3; i++) begin
			check("tx word", u.got[i], tbl[i]);
		end
		check("tx single bit", u.got[3], 21'h000001);
		check("pair faults", 21'(u.pair_bad), 21'h000000);
		check("tx_ready", 21'(rdy), 21'h000001);
	endtask

	task t_rx_word(input logic [WORD_BITS-1:0] w);
		int n;
		u.send_word(w);
		for (n = 0; n < 40 && strobe !== 1'h0; n++) @(posedge clk);
		for (n = 0; n < 40 && strobe !== 1'h1; n++) @(posedge clk);
		check("rx word", wout, w);
		check("rx strobe", 21'(strobe), 21'h000001);
	endtask

	task t_tx_sleep;
		@(negedge clk);
		tx_sleep_n = 1'h0;
		repeat (6) @(negedge clk);
		check("oe_n asleep", 21'({lo, fo}), 21'h000003);
		tx_sleep_n = 1'h1;
		repeat (6) @(negedge clk);
		check("oe_n awake", 21'({lo, fo}), 21'h000000);
	endtask

	task t_rx_sleep;
		@(negedge clk);
		rx_sleep_n = 1'h0;
		repeat (5) @(negedge clk);
		check("word asleep", wout, 21'h000000);
		check("strobe asleep", 21'(strobe), 21'h000000);
		rx_sleep_n = 1'h1;
		repeat (4) @(negedge clk);
		t_rx_word(21'h0F0F0F);
	endtask

	initial begin
		// a real falling edge, so the async resets of both clock domains fire
		#1;
		reset_n = 1'h0;
		@(negedge clk);
		t_reset;
		repeat (2) @(negedge clk);
		reset_n = 1'h1;
		repeat (4) @(negedge clk);
		t_tx_words;
		for (int i = 0; i < 3; i++) begin
			t_rx_word(tbl[i]);
		end
		t_rx_word(21'h000001);
		t_tx_sleep;
		t_rx_sleep;
		final_report;
	end

	// the whole sequence needs about one microsecond
	initial begin
		#20000;
		n_mismatch++;
		final_report;
	end
endmodule
